/* File: zsp_ctl_end.sv */
// controller end: queues requests, issues loads and advances, collects reads
`timescale 1ns/100ps
`include "zsp_params.svh"
module zsp_ctl_end
	import zsp_pkg::*;
(
	input  wire logic                   mclk,       // clock
	input  wire logic                   rst_n,      // async reset, low
	zsp_bus_if.ctl                      bus,        // pins toward the sram
	input  wire logic                   reqValid,   // request offered
	output logic                        reqReady,   // request queue has room
	input  wire logic [`ZSP_REQ_W-1:0]  reqData,    // {op,lanes,addr,rsvd,data,par}
	input  wire logic                   strapInterleave, // burst order choice
	output logic                        rdValid,    // read word pulse
	output logic [`ZSP_DATA_W-1:0]      rdData,     // read data
	output logic [`ZSP_PAR_W-1:0]       rdPar       // read parity
);
	typedef struct packed {
		logic [`ZSP_ADDR_W-1:0] addr;
		logic                   rnw;
		logic                   adv;
		logic                   susp;
		logic                   csN;
		logic [3:0]             lanesN;
		logic                   strapN;
		logic [`ZSP_DATA_W-1:0] wrData;
		logic [`ZSP_PAR_W-1:0]  wrPar;
		logic                   wrPhase;  // drive dq this cycle
		logic                   rdPhase;  // sample dq at next edge
		logic [`ZSP_DATA_W-1:0] nextData;
		logic [`ZSP_PAR_W-1:0]  nextPar;
		logic                   nextWr;
		logic                   nextRd;
		logic                   burstRead; // direction of current burst
		logic                   burstOn;   // a burst is open for advances
		logic                   rdValid;
		logic [`ZSP_DATA_W-1:0] rdData;
		logic [`ZSP_PAR_W-1:0]  rdPar;
	} zsp_ctl_s;
	zsp_ctl_s st_reg, st_next;
	logic qValid, qPop;
	logic [`ZSP_REQ_W-1:0] qData;
	zsp_op_e op;

	zsp_fifo #(.WIDTH(`ZSP_REQ_W), .DEPTH(`ZSP_FIFO_DEPTH)) uQueue (
		.mclk(mclk), .rst_n(rst_n), .inValid(reqValid), .inReady(reqReady), .inData(reqData),
		.outValid(qValid), .outReady(qPop), .outData(qData));

	assign op   = zsp_op_e'(qData[`ZSP_REQ_W-1 -: 3]);
	assign qPop = 1'b1;

	// one request per cycle; empty queue issues a deselect
	always_comb begin
		st_next = st_reg;
		st_next.strapN = strapInterleave; // R1 R2
		st_next.rdValid = 1'b0;
		if (st_reg.rdPhase && !st_reg.susp) begin
			st_next.rdValid = 1'b1;
			st_next.rdData = bus.dqFromMem;
			st_next.rdPar = bus.dqpFromMem;
		end
		if (!st_reg.susp) begin
			st_next.wrPhase = st_reg.nextWr;
			st_next.rdPhase = st_reg.nextRd;
			st_next.wrData = st_reg.nextData;
			st_next.wrPar = st_reg.nextPar;
		end
		st_next.susp = 1'b0;
		st_next.adv = 1'b1;
		st_next.csN = 1'b0;
		st_next.nextWr = 1'b0;
		st_next.nextRd = 1'b0;
		if (qValid) begin
			st_next.lanesN = qData[`ZSP_REQ_W-4 -: 4];
			st_next.nextData = qData[`ZSP_PAR_W +: `ZSP_DATA_W];
			st_next.nextPar = qData[`ZSP_PAR_W-1:0];
			case (op)
				ZSP_OP_LOAD_RD, ZSP_OP_LOAD_WR: begin
					st_next.adv = 1'b0; // R4
					st_next.burstOn = 1'b1;
					st_next.addr = qData[`ZSP_REQ_W-8 -: `ZSP_ADDR_W];
					st_next.rnw = (op == ZSP_OP_LOAD_RD);
					st_next.burstRead = (op == ZSP_OP_LOAD_RD);
					st_next.nextRd = (op == ZSP_OP_LOAD_RD);
					st_next.nextWr = (op == ZSP_OP_LOAD_WR);
				end
				ZSP_OP_ADV: begin
					st_next.nextRd = st_reg.burstOn && st_reg.burstRead; // R11 R12
					st_next.nextWr = st_reg.burstOn && !st_reg.burstRead;
				end
				ZSP_OP_DESEL: begin
					st_next.adv = 1'b0;
					st_next.csN = 1'b1;
					st_next.burstOn = 1'b0;
				end
				ZSP_OP_SUSPEND: begin
					st_next.susp = 1'b1;
					st_next.nextWr = st_reg.nextWr;
					st_next.nextRd = st_reg.nextRd;
				end
				default: begin
					st_next.csN = 1'b1;
					st_next.adv = 1'b0;
					st_next.burstOn = 1'b0;
				end
			endcase
		end else begin
			st_next.csN = 1'b1;
			st_next.adv = 1'b0;
			st_next.burstOn = 1'b0;
		end
	end

	// state register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) st_reg <= '{csN: 1'b1, susp: 1'b0, lanesN: 4'hf, strapN: 1'b1,
			default: '0};
		else st_reg <= st_next;
	end

	assign bus.addr             = st_reg.addr;
	assign bus.readNotWrite     = st_reg.rnw;
	assign bus.advanceNotLoad   = st_reg.adv;
	assign bus.clockSuspendN    = !st_reg.susp;
	assign bus.chipSelectAN     = st_reg.csN;
	assign bus.chipSelectB      = 1'b1;
	assign bus.byteLaneWriteN   = st_reg.lanesN;
	assign bus.burstOrderStrapN = st_reg.strapN;
	assign bus.outputEnableN    = !st_reg.rdPhase; // R17
	assign bus.dqFromCtl        = st_reg.wrData;
	assign bus.dqpFromCtl       = st_reg.wrPar;
	assign bus.dqOeCtl          = st_reg.wrPhase;
	assign rdValid              = st_reg.rdValid;
	assign rdData               = st_reg.rdData;
	assign rdPar                = st_reg.rdPar;
endmodule : zsp_ctl_end

/* File: zsp_params.svh */
// constants for the zero-turnaround burst sram port
`ifndef ZSP_PARAMS_SVH
`define ZSP_PARAMS_SVH
`define ZSP_ADDR_W     17
`define ZSP_DATA_W     32
`define ZSP_PAR_W      4
`define ZSP_LANE_W     8
`define ZSP_BURST_LEN  4
`define ZSP_MEM_WORDS  256
`define ZSP_MEM_IDX_W  8
`define ZSP_FIFO_DEPTH 8
`define ZSP_REQ_W      (1 + 4 + `ZSP_ADDR_W + 4 + `ZSP_DATA_W + `ZSP_PAR_W)
`endif

/* File: zsp_pkg.sv */
// types shared by both ends of the burst sram port
`include "zsp_params.svh"
package zsp_pkg;
	typedef enum logic [1:0] {ZSP_IDLE, ZSP_READ, ZSP_WRITE} zsp_phase_e;
	typedef enum logic [2:0] {ZSP_OP_LOAD_RD, ZSP_OP_LOAD_WR, ZSP_OP_ADV, ZSP_OP_DESEL,
		ZSP_OP_SUSPEND} zsp_op_e;
	typedef logic [`ZSP_ADDR_W-1:0] zsp_addr_t;
	typedef logic [`ZSP_DATA_W-1:0] zsp_data_t;
endpackage : zsp_pkg

/* File: zsp_bus_if.sv */
// pin-level bus between the memory controller and the sram port
`timescale 1ns/100ps
`include "zsp_params.svh"
interface zsp_bus_if;
	logic [`ZSP_ADDR_W-1:0] addr;
	logic                   readNotWrite;
	logic                   advanceNotLoad;
	logic                   clockSuspendN;
	logic                   chipSelectAN;
	logic                   chipSelectB;
	logic [3:0]             byteLaneWriteN;
	logic                   burstOrderStrapN;
	logic                   outputEnableN;
	logic [`ZSP_DATA_W-1:0] dqFromCtl;
	logic [`ZSP_PAR_W-1:0]  dqpFromCtl;
	logic                   dqOeCtl;
	logic [`ZSP_DATA_W-1:0] dqFromMem;
	logic [`ZSP_PAR_W-1:0]  dqpFromMem;
	logic                   dqOeMem;
	modport mem (input addr, readNotWrite, advanceNotLoad, clockSuspendN, chipSelectAN,
		chipSelectB, byteLaneWriteN, burstOrderStrapN, outputEnableN, dqFromCtl, dqpFromCtl,
		dqOeCtl, output dqFromMem, dqpFromMem, dqOeMem);
	modport ctl (output addr, readNotWrite, advanceNotLoad, clockSuspendN, chipSelectAN,
		chipSelectB, byteLaneWriteN, burstOrderStrapN, outputEnableN, dqFromCtl, dqpFromCtl,
		dqOeCtl, input dqFromMem, dqpFromMem, dqOeMem);
endinterface : zsp_bus_if

/* File: zsp_fifo.sv */
// parameterised valid/ready fifo
`timescale 1ns/100ps
module zsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,      // clock
	input  wire logic             rst_n,     // async reset, low
	input  wire logic             inValid,   // write offered
	output logic                  inReady,   // room available
	input  wire logic [WIDTH-1:0] inData,    // write word
	output logic                  outValid,  // word available
	input  wire logic             outReady,  // consumer takes
	output logic [WIDTH-1:0]      outData    // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] memArr [DEPTH];
	typedef struct packed {
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0]   count;
	} zsp_fifo_s;
	zsp_fifo_s st_reg, st_next;
	logic push, pop;

	// handshake terms
	assign inReady  = (st_reg.count != (AW+1)'(DEPTH));
	assign outValid = (st_reg.count != '0);
	assign outData  = memArr[st_reg.rdPtr];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// pointer and count update
	always_comb begin
		st_next = st_reg;
		if (push) st_next.wrPtr = st_reg.wrPtr + 1'b1;
		if (pop) st_next.rdPtr = st_reg.rdPtr + 1'b1;
		st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
	end

	// state register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) st_reg <= '0;
		else st_reg <= st_next;
	end

	// storage, no reset needed
	always_ff @(posedge mclk) begin
		if (push) memArr[st_reg.wrPtr] <= inData;
	end
endmodule : zsp_fifo

/* File: zsp_mem_end.sv */
// sram device end: burst counter, pipelined data phase, byte-lane writes
// What this block and the controller end do
// R1: strap high: address XOR burst index
// R2: strap low: low bits count up mod four
// R3: counter wraps to start, keeps counting
// R4: controller loads address with advance low
// R5: load read data driven next cycle
// R6: advance steps counter; data lags one edge
// R7: new load ends burst after current beat
// R8: 32+4 bits, data one cycle after address
// R9: inputs captured on rising edge only
// R10: read/write switch with no gap
// R11: advance after deselect is no-op
// R12: advance ignores read/write, keeps direction
// R13: suspend freezes everything for that edge
// R14: deselect load: bus off one cycle later
// R15: byte lane enables write lane plus parity
// R16: counter touches only two low bits
// R17: controller drives output enable during reads
`timescale 1ns/100ps
`include "zsp_params.svh"
module zsp_mem_end
	import zsp_pkg::*;
(
	input  wire logic mclk,     // clock
	input  wire logic rst_n,    // async reset, low
	zsp_bus_if.mem    bus,      // pins toward the controller
	output logic      busyRead, // a read data phase is on the bus
	output logic      busyWrite // a write data phase is active
);
	typedef struct packed {
		zsp_phase_e             phase;     // kind of pending data phase
		logic [`ZSP_ADDR_W-1:0] baseAddr;  // address as loaded
		logic [1:0]             burstIdx;  // beats since load
		logic [`ZSP_ADDR_W-1:0] dataAddr;  // address of pending data phase
		logic [3:0]             lanesN;    // byte lanes taken with the address phase
		logic                   busyRead;
		logic                   busyWrite;
	} zsp_mem_s;
	zsp_mem_s st_reg, st_next;
	logic [`ZSP_MEM_IDX_W-1:0]         wrIdx, rdIdx;
	logic [`ZSP_DATA_W+`ZSP_PAR_W-1:0] rdWord;
	logic                              selected, active;
	logic [1:0]                        stepIdx, lowBits;

	assign selected = !bus.chipSelectAN && bus.chipSelectB;
	assign active   = bus.clockSuspendN; // R13
	assign stepIdx  = st_reg.burstIdx + 2'd1; // R3

	// next burst address low bits
	always_comb begin
		if (bus.burstOrderStrapN) lowBits = st_reg.baseAddr[1:0] ^ stepIdx; // R1
		else lowBits = st_reg.baseAddr[1:0] + stepIdx; // R2
	end

	// sequencing of load, advance, deselect
	always_comb begin
		st_next = st_reg;
		if (active) begin // R9
			if (!bus.advanceNotLoad) begin // R7
				if (selected) begin // R4
					st_next.baseAddr = bus.addr;
					st_next.dataAddr = bus.addr;
					st_next.burstIdx = 2'd0;
					st_next.lanesN = bus.byteLaneWriteN; // R15
					st_next.phase = bus.readNotWrite ? ZSP_READ : ZSP_WRITE; // R10
				end else begin
					st_next.phase = ZSP_IDLE; // R14
				end
			end else if (st_reg.phase != ZSP_IDLE) begin // R11
				st_next.burstIdx = stepIdx; // R6 R12
				st_next.dataAddr = {st_reg.baseAddr[`ZSP_ADDR_W-1:2], lowBits}; // R16
				st_next.lanesN = bus.byteLaneWriteN; // R15
			end
			st_next.busyRead = (st_next.phase == ZSP_READ);
			st_next.busyWrite = (st_next.phase == ZSP_WRITE);
		end
	end

	// state register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) st_reg <= '{phase: ZSP_IDLE, lanesN: 4'hf, default: '0};
		else st_reg <= st_next;
	end

	assign wrIdx = st_reg.dataAddr[`ZSP_MEM_IDX_W-1:0];
	assign rdIdx = st_reg.dataAddr[`ZSP_MEM_IDX_W-1:0];

	// per-lane storage of data byte plus parity bit; each lane owns its array so
	// no two processes write the same memory
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gLane
			logic [`ZSP_LANE_W:0] laneArr [`ZSP_MEM_WORDS];
			always_ff @(posedge mclk) begin
				if (active && st_reg.phase == ZSP_WRITE && !st_reg.lanesN[g]) begin // R15
					laneArr[wrIdx] <= {bus.dqpFromCtl[g],
						bus.dqFromCtl[g*`ZSP_LANE_W +: `ZSP_LANE_W]};
				end
			end
			assign rdWord[g*`ZSP_LANE_W +: `ZSP_LANE_W] = laneArr[rdIdx][`ZSP_LANE_W-1:0];
			assign rdWord[`ZSP_DATA_W+g]                = laneArr[rdIdx][`ZSP_LANE_W];
		end
	endgenerate

	// flow-through read output during the data phase
	assign bus.dqFromMem  = rdWord[`ZSP_DATA_W-1:0]; // R5 R8
	assign bus.dqpFromMem = rdWord[`ZSP_DATA_W +: `ZSP_PAR_W];
	assign bus.dqOeMem    = (st_reg.phase == ZSP_READ) && !bus.outputEnableN; // R17
	assign busyRead       = st_reg.busyRead;
	assign busyWrite      = st_reg.busyWrite;
endmodule : zsp_mem_end

/* File: zsp_bus_checker.sv */
// concurrent checks on the pin-level bus between controller and sram ends
`timescale 1ns/100ps
module zsp_bus_checker (
	input wire logic        mclk,           // clock
	input wire logic        rst_n,          // async reset, low
	input wire logic        advanceNotLoad, // 1 = advance
	input wire logic        readNotWrite,   // 1 = read
	input wire logic        clockSuspendN,  // 1 = edge taken
	input wire logic        chipSelectAN,   // select, low
	input wire logic        chipSelectB,    // select, high
	input wire logic        outputEnableN,  // read enable, low
	input wire logic        dqOeMem,        // sram drives data
	input wire logic        dqOeCtl,        // controller drives data
	input wire logic [31:0] dqFromMem       // sram data
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// decoded bus cycles
	sequence s_sel;
		clockSuspendN && !advanceNotLoad && !chipSelectAN && chipSelectB;
	endsequence
	sequence s_load_rd; s_sel and readNotWrite; endsequence
	sequence s_load_wr; s_sel and !readNotWrite; endsequence
	sequence s_desel;
		clockSuspendN && !advanceNotLoad && (chipSelectAN || !chipSelectB);
	endsequence
	sequence s_adv; clockSuspendN && advanceNotLoad; endsequence
	a_read_data_next: assert property (s_load_rd |=> dqOeMem) else $error("no read data");
	a_read_oe_low: assert property (s_load_rd |=> !outputEnableN) else $error("oe high");
	a_write_ctl_drives: assert property (s_load_wr |=> dqOeCtl && !dqOeMem)
		else $error("write data phase wrong");
	a_desel_bus_off: assert property (s_desel |=> !dqOeMem) else $error("bus not off");
	a_noop_after_desel: assert property (s_desel ##1 s_adv |=> !dqOeMem)
		else $error("advance after deselect drove bus");
	a_adv_read_dir: assert property (s_load_rd ##1 s_adv |=> dqOeMem)
		else $error("read burst stopped");
	a_adv_write_dir: assert property (s_load_wr ##1 s_adv |=> !dqOeMem && dqOeCtl)
		else $error("write burst turned");
	a_no_contention: assert property (!(dqOeMem && dqOeCtl)) else $error("both drive");
	a_suspend_holds: assert property (!clockSuspendN ##1 $stable(outputEnableN) |->
		$stable(dqOeMem) && (!dqOeMem || $stable(dqFromMem))) else $error("suspend moved bus");
endmodule : zsp_bus_checker

/* File: testbench.sv */
// self-checking bench joining the controller and sram ends
`timescale 1ns/100ps
`include "zsp_params.svh"
module testbench;
	import zsp_pkg::*;
	logic                  mclk = 0;
	logic                  rst_n = 0;
	logic                  reqValid = 0;
	logic                  reqReady;
	logic [`ZSP_REQ_W-1:0] reqData = '0;
	logic                  strapInterleave = 0;
	logic                  rdValid;
	logic [31:0]           rdData;
	logic [3:0]            rdPar;
	logic [35:0]           memModel [256];
	logic [35:0]           expQ [$];
	logic [35:0]           gotQ [$];
	int                    error_cnt = 0;
	int                    n_checks = 0;
	int                    cyc = 0;
	logic                  memBusyRead;
	logic                  memBusyWrite;
	zsp_bus_if bus();
	zsp_mem_end u_zsp_mem_end (.mclk(mclk), .rst_n(rst_n), .bus(bus), .busyRead(memBusyRead),
		.busyWrite(memBusyWrite));
	zsp_ctl_end u_zsp_ctl_end (.mclk(mclk), .rst_n(rst_n), .bus(bus), .reqValid(reqValid),
		.reqReady(reqReady), .reqData(reqData), .strapInterleave(strapInterleave),
		.rdValid(rdValid), .rdData(rdData), .rdPar(rdPar));
	zsp_bus_checker u_zsp_bus_checker (.mclk(mclk), .rst_n(rst_n),
		.advanceNotLoad(bus.advanceNotLoad), .readNotWrite(bus.readNotWrite),
		.clockSuspendN(bus.clockSuspendN), .chipSelectAN(bus.chipSelectAN),
		.chipSelectB(bus.chipSelectB), .outputEnableN(bus.outputEnableN),
		.dqOeMem(bus.dqOeMem), .dqOeCtl(bus.dqOeCtl), .dqFromMem(bus.dqFromMem));
	// clock, cycle ceiling and read capture
	always #4 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			$display("mismatch at %0t: run did not finish", $time);
			results();
		end
	end
	always @(negedge mclk) if (rdValid === 1'b1) gotQ.push_back({rdPar, rdData});
	// sram data-phase flags against the controller's own data phases
	always @(negedge mclk) begin
		if (rst_n) begin
			chk_flag(memBusyRead, !bus.outputEnableN);
			chk_flag(memBusyWrite, bus.dqOeCtl);
		end
	end
	task chk_flag(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: flag %b expected %b", $time, g, e);
		end
	endtask : chk_flag
	task chk_word(input logic [35:0] g, input logic [35:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: word %h expected %h", $time, g, e);
		end
	endtask : chk_word
	task chk_cnt(input int g, input int e);
		n_checks++;
		if (g != e) begin
			error_cnt++;
			$display("mismatch at %0t: %0d reads expected %0d", $time, g, e);
		end
	endtask : chk_cnt
	// offer one request and hold it until the queue takes it
	task push(input logic [2:0] op, input logic [3:0] ln, input logic [16:0] a,
		input logic [35:0] w);
		logic [`ZSP_REQ_W-1:0] d;
		logic                  ok;
		d = '0;
		d[`ZSP_REQ_W-1 -: 3] = op;
		d[`ZSP_REQ_W-4 -: 4] = ln;
		d[`ZSP_REQ_W-8 -: 17] = a;
		d[35:4] = w[31:0];
		d[3:0] = w[35:32];
		reqData = d;
		reqValid = 1'b1;
		do begin
			ok = reqReady;
			@(posedge mclk);
			#1;
		end while (ok !== 1'b1);
	endtask : push
	// one beat: load or advance, read or write, with the expected effect
	task beat(input bit ld, input bit rd, input logic [3:0] ln, input logic [16:0] a,
		input logic [35:0] w);
		push(ld ? (rd ? 3'h0 : 3'h1) : 3'h2, ln, a, w);
		if (rd) expQ.push_back(memModel[a[7:0]]);
		else for (int g = 0; g < 4; g++) if (!ln[g]) begin
			memModel[a[7:0]][8*g+:8] = w[8*g+:8];
			memModel[a[7:0]][32+g] = w[32+g];
		end
	endtask : beat
	task finish(input string name);
		reqValid = 1'b0;
		repeat (12) @(posedge mclk);
		#1;
		chk_cnt(gotQ.size(), expQ.size());
		foreach (expQ[i]) if (i < gotQ.size()) chk_word(gotQ[i], expQ[i]);
		$display("test %s done, mismatches so far %0d", name, error_cnt);
		expQ.delete();
		gotQ.delete();
	endtask : finish
	task t_linear;
		logic [7:0] wa [4];
		wa = '{8'h27, 8'h24, 8'h25, 8'h26};
		strapInterleave = 1'b0;
		for (int k = 0; k < 4; k++) beat(k == 0, 0, 4'h0, {9'h100, wa[k]}, 36'h5a5a50000 + k);
		for (int k = 0; k < 8; k++) beat(k == 0, 1, 4'h0, {9'h100, 8'h24 + 8'(k % 4)}, '0);
		finish("linear");
	endtask : t_linear
	task t_interleave;
		logic [7:0] wa [4];
		logic [7:0] ra [4];
		wa = '{8'h32, 8'h33, 8'h30, 8'h31};
		ra = '{8'h31, 8'h30, 8'h33, 8'h32};
		strapInterleave = 1'b1;
		for (int k = 0; k < 4; k++) beat(k == 0, 0, 4'h0, {9'h0, wa[k]}, 36'h3c3c30010 + k);
		for (int k = 0; k < 4; k++) beat(k == 0, 1, 4'h0, {9'h0, ra[k]}, '0);
		finish("interleave");
	endtask : t_interleave
	task t_mixed;
		strapInterleave = 1'b0;
		beat(1, 0, 4'h0, 17'h40, 36'hf11223344);
		beat(1, 0, 4'ha, 17'h40, 36'h0aabbccdd);
		beat(1, 1, 4'h0, 17'h40, '0);
		beat(1, 0, 4'h0, 17'h41, 36'h912345678);
		beat(1, 1, 4'h0, 17'h41, '0);
		beat(1, 0, 4'h0, 17'h42, 36'h6cafe0042);
		beat(1, 1, 4'h0, 17'h40, '0);
		beat(0, 1, 4'h0, 17'h41, '0);
		beat(1, 1, 4'h0, 17'h42, '0);
		finish("mixed");
	endtask : t_mixed
	task t_desel;
		strapInterleave = 1'b0;
		beat(1, 1, 4'h0, 17'h40, '0);
		push(3'h3, 4'h0, 17'h0, '0);
		push(3'h2, 4'h0, 17'h0, '0);
		beat(1, 1, 4'h0, 17'h41, '0);
		push(3'h4, 4'h0, 17'h0, '0);
		beat(0, 1, 4'h0, 17'h42, '0);
		push(3'h3, 4'h0, 17'h0, '0);
		finish("deselect");
	endtask : t_desel
	task results;
		$display("checks %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results
	// reset, then the scenarios in turn
	initial begin
		repeat (16) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		@(posedge mclk);
		#1;
		t_linear();
		t_interleave();
		t_mixed();
		t_desel();
		results();
	end
endmodule : testbench
